//--- rtl/btpr_pin_router.sv
/*
 * Pin router for the Bluetooth host link, wake lines, voice port and
 * clock request pin.
 * Assumes configuration inputs come from logic on sys_clk_i; every pin
 * input is asynchronous and passes two flip-flops before use.
 */
// Notes on behaviour
// - After reset the wake pins carry wake/GPIO and the host link pins carry UART.
// - Alternate routing puts bit clock on RTS, data out on CTS, sync on host wake, data in on device wake.
// - With the voice port rerouted the host link runs three-wire on serial in and out only.
// - The clock request pin is high whenever the Bluetooth or WLAN section needs the clock.
// - The clock request pin can be turned into the serial-audio data input.
// - Host link flow control is active low in both directions.
// - The voice bit clock is either driven out as master or taken in as slave.
// - The voice frame sync is either driven out as master or taken in as slave.
// - While the section power enable is low every output register is held in reset; the synchroniser keeps running.
`timescale 1ns/10ps

module btpr_pin_router
    import btpr_pkg::*;
(
    input  wire logic sys_clk_i,
    input  wire logic reset_i,
    input  wire logic clk_en_i,
    input  wire logic radio_section_power_enable_i,
    input  wire logic voice_route_alt_i,
    input  wire logic clk_req_as_audio_in_i,
    input  wire logic voice_clock_master_i,
    input  wire logic voice_sync_master_i,
    input  wire logic bt_clock_need_i,
    input  wire logic wlan_clock_need_i,
    input  wire logic uart_serial_out_i,
    input  wire logic uart_rts_n_i,
    output logic      uart_serial_in_o,
    output logic      uart_cts_n_o,
    input  wire logic host_wake_out_i,
    input  wire logic host_wake_oe_i,
    output logic      host_wake_in_o,
    input  wire logic device_wake_out_i,
    input  wire logic device_wake_oe_i,
    output logic      device_wake_in_o,
    input  wire logic voice_bit_clock_out_i,
    input  wire logic voice_frame_sync_out_i,
    input  wire logic voice_data_out_i,
    output logic      voice_bit_clock_in_o,
    output logic      voice_frame_sync_in_o,
    output logic      voice_data_in_o,
    output logic      audio_serial_data_in_o,
    output logic      sleep_clock_o,
    output logic      three_wire_mode_o,
    input  wire logic host_link_serial_in_i,
    output logic      host_link_serial_out_o,
    input  wire logic host_link_request_to_send_n_i,
    output logic      host_link_request_to_send_n_o,
    output logic      host_link_request_to_send_n_oe_o,
    input  wire logic host_link_clear_to_send_n_i,
    output logic      host_link_clear_to_send_n_o,
    output logic      host_link_clear_to_send_n_oe_o,
    input  wire logic host_wake_line_i,
    output logic      host_wake_line_o,
    output logic      host_wake_line_oe_o,
    input  wire logic device_wake_line_i,
    output logic      device_wake_line_o,
    output logic      device_wake_line_oe_o,
    input  wire logic clock_request_i,
    output logic      clock_request_o,
    output logic      clock_request_oe_o,
    input  wire logic sleep_clock_in_i
);

    logic [SYNC_W-1:0] sync_meta;
    logic [SYNC_W-1:0] sync_pin;
    logic [SYNC_W-1:0] pin_raw;
    logic              section_rst;
    btpr_route_t       route;
    btpr_route_t       next_route;

    // Pin side registers
    logic next_serial_out, next_rts_o, next_rts_oe, next_cts_o, next_cts_oe;
    logic next_hw_o, next_hw_oe, next_dw_o, next_dw_oe, next_creq_o, next_creq_oe;
    // Core side registers
    logic next_serial_in, next_cts_n, next_hw_in, next_dw_in;
    logic next_vclk_in, next_vsync_in, next_vdata_in, next_audio_in;
    logic next_sleep, next_three_wire;

    assign pin_raw = {radio_section_power_enable_i, sleep_clock_in_i, host_link_serial_in_i,
                      clock_request_i, device_wake_line_i, host_wake_line_i,
                      host_link_clear_to_send_n_i, host_link_request_to_send_n_i};

    // Only the general reset clears the synchroniser; the power enable
    // itself must keep passing through it to release the section.
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            sync_meta <= SYNC_RESET;
            sync_pin  <= SYNC_RESET;
        end else if (clk_en_i) begin
            sync_meta <= pin_raw;
            sync_pin  <= sync_meta;
        end
    end

    assign section_rst = reset_i | ~sync_pin[IDX_POWER_EN];

    always_comb begin
        next_route      = voice_route_alt_i ? BTPR_ROUTE_VOICE : BTPR_ROUTE_UART;
        next_serial_out = uart_serial_out_i;
        next_serial_in  = sync_pin[IDX_SERIAL_IN];
        next_sleep      = sync_pin[IDX_SLEEP_CLK];
        next_three_wire = voice_route_alt_i;
        if (voice_route_alt_i) begin
            // Bit clock on RTS pin, direction from master select
            next_rts_oe   = voice_clock_master_i;
            next_rts_o    = voice_bit_clock_out_i;
            next_vclk_in  = voice_clock_master_i ? RST_LOW : sync_pin[IDX_RTS];
            next_cts_oe   = RST_DRIVE;
            next_cts_o    = voice_data_out_i;
            next_hw_oe    = voice_sync_master_i;
            next_hw_o     = voice_frame_sync_out_i;
            next_vsync_in = voice_sync_master_i ? RST_LOW : sync_pin[IDX_HOST_WAKE];
            next_dw_oe    = RST_RELEASE;
            next_dw_o     = RST_LOW;
            next_vdata_in = sync_pin[IDX_DEV_WAKE];
            // Core UART never stalls on a pin it no longer owns
            next_cts_n    = FLOW_ASSERTED;
            next_hw_in    = RST_LOW;
            next_dw_in    = RST_LOW;
        end else begin
            next_rts_oe   = RST_DRIVE;
            next_rts_o    = uart_rts_n_i;
            next_cts_oe   = RST_RELEASE;
            next_cts_o    = RST_LOW;
            next_cts_n    = sync_pin[IDX_CTS];
            next_hw_oe    = host_wake_oe_i;
            next_hw_o     = host_wake_out_i;
            next_hw_in    = sync_pin[IDX_HOST_WAKE];
            next_dw_oe    = device_wake_oe_i;
            next_dw_o     = device_wake_out_i;
            next_dw_in    = sync_pin[IDX_DEV_WAKE];
            next_vclk_in  = RST_LOW;
            next_vsync_in = RST_LOW;
            next_vdata_in = RST_LOW;
        end
        if (clk_req_as_audio_in_i) begin
            next_creq_oe  = RST_RELEASE;
            next_creq_o   = RST_LOW;
            next_audio_in = sync_pin[IDX_CLK_REQ];
        end else begin
            next_creq_oe  = RST_DRIVE;
            next_creq_o   = bt_clock_need_i | wlan_clock_need_i;
            next_audio_in = RST_LOW;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (section_rst) begin
            route                            <= BTPR_ROUTE_UART;
            host_link_serial_out_o           <= RST_SERIAL_OUT;
            host_link_request_to_send_n_o    <= RST_RTS_N;
            host_link_request_to_send_n_oe_o <= RST_DRIVE;
            host_link_clear_to_send_n_o      <= RST_LOW;
            host_link_clear_to_send_n_oe_o   <= RST_RELEASE;
            host_wake_line_o                 <= RST_LOW;
            host_wake_line_oe_o              <= RST_RELEASE;
            device_wake_line_o               <= RST_LOW;
            device_wake_line_oe_o            <= RST_RELEASE;
            clock_request_o                  <= RST_LOW;
            clock_request_oe_o               <= RST_DRIVE;
            uart_serial_in_o                 <= RST_SERIAL_OUT;
            uart_cts_n_o                     <= RST_RTS_N;
            host_wake_in_o                   <= RST_LOW;
            device_wake_in_o                 <= RST_LOW;
            voice_bit_clock_in_o             <= RST_LOW;
            voice_frame_sync_in_o            <= RST_LOW;
            voice_data_in_o                  <= RST_LOW;
            audio_serial_data_in_o           <= RST_LOW;
            sleep_clock_o                    <= RST_LOW;
            three_wire_mode_o                <= RST_LOW;
        end else if (clk_en_i) begin
            route                            <= next_route;
            host_link_serial_out_o           <= next_serial_out;
            host_link_request_to_send_n_o    <= next_rts_o;
            host_link_request_to_send_n_oe_o <= next_rts_oe;
            host_link_clear_to_send_n_o      <= next_cts_o;
            host_link_clear_to_send_n_oe_o   <= next_cts_oe;
            host_wake_line_o                 <= next_hw_o;
            host_wake_line_oe_o              <= next_hw_oe;
            device_wake_line_o               <= next_dw_o;
            device_wake_line_oe_o            <= next_dw_oe;
            clock_request_o                  <= next_creq_o;
            clock_request_oe_o               <= next_creq_oe;
            uart_serial_in_o                 <= next_serial_in;
            uart_cts_n_o                     <= next_cts_n;
            host_wake_in_o                   <= next_hw_in;
            device_wake_in_o                 <= next_dw_in;
            voice_bit_clock_in_o             <= next_vclk_in;
            voice_frame_sync_in_o            <= next_vsync_in;
            voice_data_in_o                  <= next_vdata_in;
            audio_serial_data_in_o           <= next_audio_in;
            sleep_clock_o                    <= next_sleep;
            three_wire_mode_o                <= next_three_wire;
        end
    end

    // Slave clock and sync are sampled at 10 MHz, so only slow voice
    // clocks survive; this is a routing block, not a retimer.

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (section_rst);

    property p_uart_default;
        clk_en_i && !voice_route_alt_i |=> host_link_request_to_send_n_oe_o
            && host_link_request_to_send_n_o == $past(uart_rts_n_i)
            && !host_link_clear_to_send_n_oe_o;
    endproperty
    a_uart_default: assert property (p_uart_default)
        else $error("RTS pin not carrying UART flow control");

    property p_voice_clock_master;
        clk_en_i && voice_route_alt_i && voice_clock_master_i
            |=> host_link_request_to_send_n_oe_o
            && host_link_request_to_send_n_o == $past(voice_bit_clock_out_i);
    endproperty
    a_voice_clock_master: assert property (p_voice_clock_master)
        else $error("Voice bit clock not driven on RTS pin");

    property p_voice_clock_slave;
        clk_en_i && voice_route_alt_i && !voice_clock_master_i
            |=> !host_link_request_to_send_n_oe_o;
    endproperty
    a_voice_clock_slave: assert property (p_voice_clock_slave)
        else $error("RTS pin driven while bit clock is slave");

    property p_voice_data_pins;
        clk_en_i && voice_route_alt_i |=> host_link_clear_to_send_n_oe_o
            && host_link_clear_to_send_n_o == $past(voice_data_out_i)
            && !device_wake_line_oe_o;
    endproperty
    a_voice_data_pins: assert property (p_voice_data_pins)
        else $error("Voice data pins misrouted");

    property p_voice_sync;
        clk_en_i && voice_route_alt_i |=> host_wake_line_oe_o == $past(voice_sync_master_i)
            && (!host_wake_line_oe_o || host_wake_line_o == $past(voice_frame_sync_out_i));
    endproperty
    a_voice_sync: assert property (p_voice_sync)
        else $error("Frame sync direction or value wrong");

    property p_three_wire;
        clk_en_i && voice_route_alt_i |=> three_wire_mode_o
            && uart_cts_n_o == FLOW_ASSERTED && !device_wake_in_o && !host_wake_in_o;
    endproperty
    a_three_wire: assert property (p_three_wire)
        else $error("Flow control or wake still active in three-wire mode");

    property p_clock_request;
        clk_en_i && !clk_req_as_audio_in_i |=> clock_request_oe_o
            && clock_request_o == ($past(bt_clock_need_i) || $past(wlan_clock_need_i));
    endproperty
    a_clock_request: assert property (p_clock_request)
        else $error("Clock request not the OR of section needs");

    property p_audio_in;
        clk_en_i && clk_req_as_audio_in_i
            |=> !clock_request_oe_o && audio_serial_data_in_o == $past(sync_pin[IDX_CLK_REQ]);
    endproperty
    a_audio_in: assert property (p_audio_in)
        else $error("Clock request pin not serving as audio input");

    property p_section_reset;
        disable iff (1'b0) section_rst |=> host_link_request_to_send_n_o
            && host_link_request_to_send_n_oe_o && !three_wire_mode_o && route == BTPR_ROUTE_UART;
    endproperty
    a_section_reset: assert property (p_section_reset)
        else $error("Section reset did not restore UART routing");

endmodule : btpr_pin_router

//--- inc/btpr_pkg.sv
/*
 * Constants for the Bluetooth pin router: synchroniser bit positions,
 * pin reset levels and the nominal clock figures.
 * Assumes a single 10 MHz system clock and asynchronous pin inputs.
 */
package btpr_pkg;

    // Positions in the pin synchroniser vector
    localparam int SYNC_W         = 8;
    localparam int IDX_RTS        = 0;
    localparam int IDX_CTS        = 1;
    localparam int IDX_HOST_WAKE  = 2;
    localparam int IDX_DEV_WAKE   = 3;
    localparam int IDX_CLK_REQ    = 4;
    localparam int IDX_SERIAL_IN  = 5;
    localparam int IDX_SLEEP_CLK  = 6;
    localparam int IDX_POWER_EN   = 7;

    localparam logic [SYNC_W-1:0] SYNC_RESET = 8'h00;

    // Pin levels while the section is held in reset
    localparam logic RST_RTS_N      = 1'h1;
    localparam logic RST_SERIAL_OUT = 1'h1;
    localparam logic RST_LOW        = 1'h0;
    localparam logic RST_DRIVE      = 1'h1;
    localparam logic RST_RELEASE    = 1'h0;

    // Flow control is active low: low means asserted
    localparam logic FLOW_ASSERTED  = 1'h0;

    // Nominal clocks; the sleep clock is only sampled and passed on
    localparam int SYS_CLOCK_HZ     = 32'h0098_9680;
    localparam int SLEEP_CLOCK_HZ   = 32'h0000_8000;

    typedef enum logic {
        BTPR_ROUTE_UART,
        BTPR_ROUTE_VOICE
    } btpr_route_t;

endpackage : btpr_pkg

//--- tb/btpr_host_model.sv
/* Host-side model of the shared Bluetooth pins and the sleep clock.
   Assumes the bench commands which lines the host drives and to what. */
`timescale 1ns/10ps

module btpr_host_model (
    input  wire logic       sys_clk_i,
    input  wire logic [4:0] dev_o_i,
    input  wire logic [4:0] dev_oe_i,
    input  wire logic [4:0] host_val_i,
    input  wire logic [4:0] host_oe_i,
    output logic      [4:0] line_o,
    output logic            sleep_clock_o,
    output logic            clash_o
);
    logic [4:0] idle_pat;

    // Released lines toggle so a stale level never passes as data
    initial begin
        idle_pat = 5'h00;
        forever @(negedge sys_clk_i) idle_pat <= ~idle_pat;
    end

    // Sticky: both sides drove one line in the half cycle before an edge
    initial begin
        clash_o = 1'h0;
        forever begin
            @(posedge sys_clk_i);
            if (|(dev_oe_i & host_oe_i)) clash_o <= 1'h1;
        end
    end

    always_comb begin
        for (int i = 0; i < 5; i++) begin
            if (dev_oe_i[i] && host_oe_i[i]) begin
                line_o[i] = 1'hx;
            end else if (dev_oe_i[i]) begin
                line_o[i] = dev_o_i[i];
            end else begin
                line_o[i] = host_oe_i[i] ? host_val_i[i] : idle_pat[i];
            end
        end
    end

    initial begin
        sleep_clock_o = 1'h0;
        forever #15259 sleep_clock_o = ~sleep_clock_o;
    end
endmodule : btpr_host_model

//--- tb/btpr_pin_router_tb_top.sv
/* Self-checking bench for the Bluetooth pin router.
   Assumes the host model resolves every shared pin. */
`timescale 1ns/10ps

module btpr_pin_router_tb_top;
    import btpr_pkg::*;
    logic sys_clk_i, reset_i, clk_en_i, radio_section_power_enable_i, voice_route_alt_i;
    logic clk_req_as_audio_in_i, voice_clock_master_i, voice_sync_master_i;
    logic bt_clock_need_i, wlan_clock_need_i, uart_serial_out_i, uart_rts_n_i;
    logic host_wake_out_i, host_wake_oe_i, device_wake_out_i, device_wake_oe_i;
    logic voice_bit_clock_out_i, voice_frame_sync_out_i, voice_data_out_i, host_link_serial_in_i;
    logic uart_serial_in_o, uart_cts_n_o, host_wake_in_o, device_wake_in_o, voice_bit_clock_in_o;
    logic voice_frame_sync_in_o, voice_data_in_o, audio_serial_data_in_o, sleep_clock_o;
    logic three_wire_mode_o, host_link_serial_out_o, clock_request_o, clock_request_oe_o;
    logic host_link_request_to_send_n_o, host_link_request_to_send_n_oe_o;
    logic host_link_clear_to_send_n_o, host_link_clear_to_send_n_oe_o;
    logic host_wake_line_o, host_wake_line_oe_o, device_wake_line_o, device_wake_line_oe_o;
    logic [4:0] host_val, host_oe, line;
    logic       sleep_clock_in_i, clash;
    int         errors = 0, total_checks = 0, cycles = 0;
    wire logic  host_link_request_to_send_n_i = line[0];
    wire logic  host_link_clear_to_send_n_i   = line[1];
    wire logic  host_wake_line_i              = line[2];
    wire logic  device_wake_line_i            = line[3];
    wire logic  clock_request_i               = line[4];
    wire logic [7:0] pins = {host_link_request_to_send_n_oe_o, host_link_request_to_send_n_o,
        host_link_clear_to_send_n_oe_o, host_link_clear_to_send_n_o, host_wake_line_oe_o,
        host_wake_line_o, device_wake_line_oe_o, three_wire_mode_o};
    wire logic [7:0] core = {uart_cts_n_o, host_wake_in_o, device_wake_in_o, voice_bit_clock_in_o,
        voice_frame_sync_in_o, voice_data_in_o, audio_serial_data_in_o, uart_serial_in_o};

    btpr_pin_router u_btpr_pin_router (.sys_clk_i, .reset_i, .clk_en_i,
        .radio_section_power_enable_i, .voice_route_alt_i, .clk_req_as_audio_in_i,
        .voice_clock_master_i, .voice_sync_master_i, .bt_clock_need_i, .wlan_clock_need_i,
        .uart_serial_out_i, .uart_rts_n_i, .uart_serial_in_o, .uart_cts_n_o, .host_wake_out_i,
        .host_wake_oe_i, .host_wake_in_o, .device_wake_out_i, .device_wake_oe_i,
        .device_wake_in_o, .voice_bit_clock_out_i, .voice_frame_sync_out_i, .voice_data_out_i,
        .voice_bit_clock_in_o, .voice_frame_sync_in_o, .voice_data_in_o, .audio_serial_data_in_o,
        .sleep_clock_o, .three_wire_mode_o, .host_link_serial_in_i, .host_link_serial_out_o,
        .host_link_request_to_send_n_i, .host_link_request_to_send_n_o,
        .host_link_request_to_send_n_oe_o, .host_link_clear_to_send_n_i,
        .host_link_clear_to_send_n_o, .host_link_clear_to_send_n_oe_o, .host_wake_line_i,
        .host_wake_line_o, .host_wake_line_oe_o, .device_wake_line_i, .device_wake_line_o,
        .device_wake_line_oe_o, .clock_request_i, .clock_request_o, .clock_request_oe_o,
        .sleep_clock_in_i);

    btpr_host_model u_btpr_host_model (.sys_clk_i, .host_val_i(host_val), .host_oe_i(host_oe),
        .dev_o_i({clock_request_o, device_wake_line_o, host_wake_line_o,
                  host_link_clear_to_send_n_o, host_link_request_to_send_n_o}),
        .dev_oe_i({clock_request_oe_o, device_wake_line_oe_o, host_wake_line_oe_o,
                   host_link_clear_to_send_n_oe_o, host_link_request_to_send_n_oe_o}),
        .line_o(line), .sleep_clock_o(sleep_clock_in_i), .clash_o(clash));

    initial begin
        sys_clk_i = 1'h0;
        forever #50 sys_clk_i = ~sys_clk_i;
    end

    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask : cyc

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic end_of_test();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_of_test

    // Hang guard: whole run needs well under this
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            end_of_test();
        end
    end

    task automatic t_normal();
        uart_rts_n_i = 1'h0; host_wake_oe_i = 1'h1; host_wake_out_i = 1'h1;
        host_oe = 5'h0a; host_val = 5'h08; host_link_serial_in_i = 1'h0;
        cyc(4);
        chk(pins, 8'h8c);
        chk(core, 8'h60);
        uart_rts_n_i = 1'h1; host_val = 5'h0a; host_link_serial_in_i = 1'h1; uart_serial_out_i = 1'h1;
        cyc(4);
        chk(pins, 8'hcc);
        chk(core, 8'he1);
        chk({7'h00, host_link_serial_out_o}, 8'h01);
        // Host lets go of device wake first, the core then drives it
        host_oe = 5'h02; device_wake_oe_i = 1'h1; device_wake_out_i = 1'h1;
        cyc(4);
        chk({5'h00, device_wake_line_oe_o, device_wake_line_o, device_wake_in_o}, 8'h07);
        device_wake_oe_i = 1'h0;
        cyc(1);
    endtask : t_normal

    task automatic t_alt_master();
        voice_route_alt_i = 1'h1; voice_clock_master_i = 1'h1; voice_sync_master_i = 1'h1;
        voice_bit_clock_out_i = 1'h1; voice_data_out_i = 1'h1; uart_rts_n_i = 1'h0;
        host_oe = 5'h08; host_val = 5'h08; host_link_serial_in_i = 1'h0;
        cyc(4);
        chk(pins, 8'hf9);
        chk(core, 8'h04);
        voice_bit_clock_out_i = 1'h0; voice_frame_sync_out_i = 1'h1; voice_data_out_i = 1'h0;
        uart_rts_n_i = 1'h1; host_val = 5'h00; host_link_serial_in_i = 1'h1;
        cyc(4);
        chk(pins, 8'had);
        chk(core, 8'h01);
    endtask : t_alt_master

    task automatic t_alt_slave();
        voice_clock_master_i = 1'h0; voice_sync_master_i = 1'h0;
        // Host drives only once the router has let go of the pins
        cyc(1);
        host_oe = 5'h0d; host_val = 5'h09;
        cyc(4);
        chk(pins & 8'hbb, 8'h21);
        chk(core, 8'h15);
        host_val = 5'h04;
        cyc(4);
        chk(core, 8'h09);
    endtask : t_alt_slave

    task automatic t_clock_req();
        for (int i = 0; i < 4; i++) begin
            bt_clock_need_i = i[0]; wlan_clock_need_i = i[1];
            cyc(2);
            chk({6'h00, clock_request_oe_o, clock_request_o}, {6'h00, 1'h1, i != 0});
        end
        // Clock enable low must freeze the request output
        clk_en_i = 1'h0; bt_clock_need_i = 1'h0; wlan_clock_need_i = 1'h0;
        cyc(2);
        chk({6'h00, clock_request_oe_o, clock_request_o}, 8'h03);
        clk_en_i = 1'h1;
        cyc(2);
        chk({6'h00, clock_request_oe_o, clock_request_o}, 8'h02);
        clk_req_as_audio_in_i = 1'h1;
        cyc(1);
        host_oe = 5'h10; host_val = 5'h10;
        cyc(4);
        chk({6'h00, clock_request_oe_o, audio_serial_data_in_o}, 8'h01);
    endtask : t_clock_req

    task automatic t_power();
        voice_route_alt_i = 1'h1; host_oe = 5'h00; radio_section_power_enable_i = 1'h0;
        cyc(4);
        chk(pins, 8'hc0);
        radio_section_power_enable_i = 1'h1;
        cyc(4);
        chk({7'h00, three_wire_mode_o}, 8'h01);
        chk({7'h00, sleep_clock_o}, 8'h00);
        @(posedge sleep_clock_in_i);
        cyc(5);
        chk({7'h00, sleep_clock_o}, 8'h01);
        chk({7'h00, clash}, 8'h00);
    endtask : t_power

    initial begin
        {clk_en_i, radio_section_power_enable_i, reset_i} = 3'h7;
        {voice_route_alt_i, clk_req_as_audio_in_i, voice_clock_master_i} = 3'h0;
        {voice_sync_master_i, bt_clock_need_i, wlan_clock_need_i, uart_serial_out_i} = 4'h0;
        {uart_rts_n_i, host_wake_out_i, host_wake_oe_i, device_wake_out_i} = 4'h0;
        {device_wake_oe_i, voice_bit_clock_out_i, voice_frame_sync_out_i} = 3'h0;
        {voice_data_out_i, host_link_serial_in_i} = 2'h3;
        host_val = 5'h00; host_oe = 5'h00;
        cyc(4);
        chk(pins, 8'hc0);
        chk(core, 8'h81);
        chk({5'h00, host_link_serial_out_o, clock_request_oe_o, clock_request_o}, 8'h06);
        reset_i = 1'h0;
        cyc(4);
        t_normal();
        t_alt_master();
        t_alt_slave();
        t_clock_req();
        t_power();
        end_of_test();
    end
endmodule : btpr_pin_router_tb_top
